/* File: rtl/rsc_regs.sv */
// Status and calibration register bank of the radio
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
// Behaviour
// - Timer count low byte, read-only, reset zero
// - Timer count high byte, read-only
// - Sync detect captures 16-bit timer value
// - Capture held, zero until first capture
// - Real DC offset, 16-bit read/write
// - Imaginary DC offset, 16-bit read/write
// - Real IQ imbalance, high byte at 0x2F6D
// - Imaginary IQ imbalance, 16-bit read/write
// - 12-bit strength, upper eight bits readable
// - Strength low nibble in status bits 6:3
// - Strength resets to invalid 0x800, high byte reads 0x80
// - Gain offset subtracted from reported strength
module rsc_regs import rsc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Radio core side
   input wire logic [15:0] wake_timer_value,
   input wire logic sync_detect,
   input wire logic [11:0] strength_raw,
   input wire logic strength_update,
   output logic [15:0] dc_real_value,
   output logic [15:0] dc_imag_value,
   output logic [15:0] imbalance_real_value,
   output logic [15:0] imbalance_imag_value,
   output logic [3:0] self_test_field
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] target, input logic wr);
      wr_hit = wr && (a == target);
   endfunction : wr_hit

   logic [15:0] timer_count_reg;
   logic [15:0] timer_capture_reg;
   logic [11:0] strength_reg;
   logic [11:0] strength_next;
   logic [7:0] gain_offset_reg;
   logic [3:0] self_test_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic count_high_latched_reg;
   logic [7:0] count_high_shadow_reg;

   // ----------------------------------------------------------------
   // Timer count and capture
   // ----------------------------------------------------------------
   // Running counter sampled every cycle as one word
   rsc_snapshot #(.WIDTH(16), .RESET_VALUE(16'h0000)) u_count (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .load(1'b1),
      .value_in(wake_timer_value),
      .value_reg(timer_count_reg)
   );

   // Capture on sync detect, held otherwise
   rsc_snapshot #(.WIDTH(16), .RESET_VALUE(16'h0000)) u_capture (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .load(sync_detect),
      .value_in(wake_timer_value),
      .value_reg(timer_capture_reg)
   );

   // Reading the low count byte freezes the high byte for the next read
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_high_latched_reg <= 1'b0;
         count_high_shadow_reg <= RST_ZERO;
      end else if (reg_rd && reg_addr == ADDR_WAKE_TIMER_COUNT_LOW) begin
         count_high_latched_reg <= 1'b1;
         count_high_shadow_reg <= timer_count_reg[15:8];
      end else if (reg_rd && reg_addr == ADDR_WAKE_TIMER_COUNT_HIGH) begin
         count_high_latched_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Calibration words
   // ----------------------------------------------------------------
   rsc_word_reg u_dc_real (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wr_high(wr_hit(reg_addr, ADDR_DC_OFFSET_REAL_HIGH, reg_wr)),
      .wr_low(wr_hit(reg_addr, ADDR_DC_OFFSET_REAL_LOW, reg_wr)),
      .wr_data(reg_wdata),
      .word_reg(dc_real_value)
   );

   rsc_word_reg u_dc_imag (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wr_high(wr_hit(reg_addr, ADDR_DC_OFFSET_IMAG_HIGH, reg_wr)),
      .wr_low(wr_hit(reg_addr, ADDR_DC_OFFSET_IMAG_LOW, reg_wr)),
      .wr_data(reg_wdata),
      .word_reg(dc_imag_value)
   );

   rsc_word_reg u_iq_real (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wr_high(wr_hit(reg_addr, ADDR_IQ_IMBALANCE_REAL_HIGH, reg_wr)),
      .wr_low(wr_hit(reg_addr, ADDR_IQ_IMBALANCE_REAL_LOW, reg_wr)),
      .wr_data(reg_wdata),
      .word_reg(imbalance_real_value)
   );

   rsc_word_reg u_iq_imag (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wr_high(wr_hit(reg_addr, ADDR_IQ_IMBALANCE_IMAG_HIGH, reg_wr)),
      .wr_low(wr_hit(reg_addr, ADDR_IQ_IMBALANCE_IMAG_LOW, reg_wr)),
      .wr_data(reg_wdata),
      .word_reg(imbalance_imag_value)
   );

   // ----------------------------------------------------------------
   // Self-test and gain offset
   // ----------------------------------------------------------------
   // Only the low nibble is stored; upper bits do not exist
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         self_test_reg <= RST_ZERO[3:0];
      end else if (wr_hit(reg_addr, ADDR_SELF_TEST_CONFIG, reg_wr)) begin
         self_test_reg <= reg_wdata[3:0] & SELF_TEST_FIELD_MASK;
      end
   end
   assign self_test_field = self_test_reg;

   // Signed offset in whole dB, applied to later measurements
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         gain_offset_reg <= RST_ZERO;
      end else if (wr_hit(reg_addr, ADDR_GAIN_OFFSET, reg_wr)) begin
         gain_offset_reg <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Signal strength
   // ----------------------------------------------------------------
   // Offset is in whole dB, strength in sixteenths; invalid passes through
   always_comb begin
      if (strength_raw == STRENGTH_INVALID) begin
         strength_next = STRENGTH_INVALID;
      end else begin
         strength_next = 12'(strength_raw - {gain_offset_reg, 4'h0});
      end
   end

   // Full 12-bit word updates at once so both bytes match
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         strength_reg <= STRENGTH_INVALID;
      end else if (strength_update) begin
         strength_reg <= strength_next;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         ADDR_WAKE_TIMER_COUNT_HIGH: begin
            rdata_next = count_high_latched_reg ? count_high_shadow_reg : timer_count_reg[15:8];
         end
         ADDR_WAKE_TIMER_COUNT_LOW: rdata_next = timer_count_reg[7:0];
         ADDR_WAKE_TIMER_CAPTURE_HIGH: rdata_next = timer_capture_reg[15:8];
         ADDR_WAKE_TIMER_CAPTURE_LOW: rdata_next = timer_capture_reg[7:0];
         ADDR_SELF_TEST_CONFIG: rdata_next = {4'h0, self_test_reg};
         ADDR_DC_OFFSET_REAL_HIGH: rdata_next = dc_real_value[15:8];
         ADDR_DC_OFFSET_REAL_LOW: rdata_next = dc_real_value[7:0];
         ADDR_DC_OFFSET_IMAG_HIGH: rdata_next = dc_imag_value[15:8];
         ADDR_DC_OFFSET_IMAG_LOW: rdata_next = dc_imag_value[7:0];
         ADDR_IQ_IMBALANCE_REAL_HIGH: rdata_next = imbalance_real_value[15:8];
         ADDR_IQ_IMBALANCE_REAL_LOW: rdata_next = imbalance_real_value[7:0];
         ADDR_IQ_IMBALANCE_IMAG_HIGH: rdata_next = imbalance_imag_value[15:8];
         ADDR_IQ_IMBALANCE_IMAG_LOW: rdata_next = imbalance_imag_value[7:0];
         ADDR_SIGNAL_STRENGTH_HIGH: rdata_next = strength_reg[11:4];
         ADDR_SIGNAL_STRENGTH_LOW: rdata_next = {1'b0, strength_reg[3:0], 3'h0};
         ADDR_GAIN_OFFSET: rdata_next = gain_offset_reg;
         default: rdata_next = UNMAPPED_READ;
      endcase
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rdata_reg <= RST_ZERO;
      end else if (reg_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= RST_ZERO;
      end
   end
   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_sync_seen;
      sync_detect ##1 1'b1;
   endsequence

   sequence s_count_low_read;
      reg_rd && reg_addr == ADDR_WAKE_TIMER_COUNT_LOW;
   endsequence

   sequence s_count_high_read;
      reg_rd && reg_addr == ADDR_WAKE_TIMER_COUNT_HIGH;
   endsequence

   a_capture_on_sync: assert property (@(posedge core_clk) disable iff (!reset_n)
      sync_detect |=> timer_capture_reg == $past(wake_timer_value))
      else $error("capture did not take timer value");

   a_capture_held: assert property (@(posedge core_clk) disable iff (!reset_n)
      !sync_detect |=> $stable(timer_capture_reg))
      else $error("capture changed without sync");

   a_capture_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_sync_seen ##0 (reg_rd && reg_addr == ADDR_WAKE_TIMER_CAPTURE_LOW && !sync_detect)
      |=> reg_rdata == $past(timer_capture_reg[7:0]))
      else $error("capture low byte read wrong");

   a_count_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> timer_count_reg == $past(wake_timer_value))
      else $error("timer count not following the timer");

   a_count_low_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_count_low_read |=> reg_rdata == $past(timer_count_reg[7:0]))
      else $error("timer low byte read wrong");

   a_count_high_pair: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_count_low_read ##1 s_count_high_read
      |=> reg_rdata == $past(timer_count_reg[15:8], 2))
      else $error("timer high byte not from same sample");

   a_dc_real_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_DC_OFFSET_REAL_LOW |=> dc_real_value[7:0] == $past(reg_wdata))
      else $error("real DC low byte not written");

   a_dc_real_high: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_DC_OFFSET_REAL_HIGH |=> dc_real_value[15:8] == $past(reg_wdata))
      else $error("real DC high byte not written");

   a_dc_imag_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_DC_OFFSET_IMAG_HIGH |=> dc_imag_value[15:8] == $past(reg_wdata))
      else $error("imag DC high byte not written");

   a_dc_imag_low: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_DC_OFFSET_IMAG_LOW |=> dc_imag_value[7:0] == $past(reg_wdata))
      else $error("imag DC low byte not written");

   a_iq_real_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == 16'h2f6d ##1 reg_rd && reg_addr == 16'h2f6d
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("IQ real high byte not at its address");

   a_iq_real_low: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_IQ_IMBALANCE_REAL_LOW |=> imbalance_real_value[7:0] == $past(reg_wdata))
      else $error("IQ real low byte not written");

   a_iq_imag_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_IQ_IMBALANCE_IMAG_LOW |=> imbalance_imag_value[7:0] == $past(reg_wdata))
      else $error("IQ imag low byte not written");

   a_iq_imag_high: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_IQ_IMBALANCE_IMAG_HIGH |=> imbalance_imag_value[15:8] == $past(reg_wdata))
      else $error("IQ imag high byte not written");

   a_strength_high: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_rd && reg_addr == ADDR_SIGNAL_STRENGTH_HIGH |=> reg_rdata == $past(strength_reg[11:4]))
      else $error("strength high byte wrong");

   a_strength_low: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_rd && reg_addr == ADDR_SIGNAL_STRENGTH_LOW |=> reg_rdata[6:3] == $past(strength_reg[3:0])
      && reg_rdata[7] == 1'b0)
      else $error("strength low nibble misplaced");

   a_strength_invalid: assert property (@(posedge core_clk)
      !reset_n |=> strength_reg == STRENGTH_INVALID)
      else $error("strength not invalid after reset");

   a_strength_offset: assert property (@(posedge core_clk) disable iff (!reset_n)
      strength_update && strength_raw != STRENGTH_INVALID
      |=> strength_reg == 12'($past(strength_raw) - {$past(gain_offset_reg), 4'h0}))
      else $error("gain offset not applied");

   a_strength_held: assert property (@(posedge core_clk) disable iff (!reset_n)
      !strength_update |=> $stable(strength_reg))
      else $error("strength changed without update");

   a_self_test_upper: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_rd && reg_addr == ADDR_SELF_TEST_CONFIG |=> reg_rdata[7:4] == 4'h0)
      else $error("self-test upper bits not zero");

   a_self_test_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_SELF_TEST_CONFIG |=> self_test_field == $past(reg_wdata[3:0]))
      else $error("self-test nibble not written");

   a_rdata_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
      !reg_rd |=> reg_rdata == RST_ZERO)
      else $error("read data not zero outside a read");
endmodule : rsc_regs

/* File: rtl/rsc_pkg.sv */
// Package: register map, field layout, reset values for the radio status/calibration bank
package rsc_pkg;
   // -----------------------------------------------------------------
   // Register indices (byte registers on a 16-bit address port)
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_IQ_IMBALANCE_REAL_HIGH = 16'h2f6d;
   localparam logic [15:0] ADDR_IQ_IMBALANCE_REAL_LOW = 16'h2f6e;
   localparam logic [15:0] ADDR_IQ_IMBALANCE_IMAG_HIGH = 16'h2f6f;
   localparam logic [15:0] ADDR_IQ_IMBALANCE_IMAG_LOW = 16'h2f70;
   localparam logic [15:0] ADDR_DC_OFFSET_REAL_HIGH = 16'h2f69;
   localparam logic [15:0] ADDR_DC_OFFSET_REAL_LOW = 16'h2f6a;
   localparam logic [15:0] ADDR_DC_OFFSET_IMAG_HIGH = 16'h2f6b;
   localparam logic [15:0] ADDR_DC_OFFSET_IMAG_LOW = 16'h2f6c;
   localparam logic [15:0] ADDR_SELF_TEST_CONFIG = 16'h2f68;
   localparam logic [15:0] ADDR_WAKE_TIMER_COUNT_HIGH = 16'h2f64;
   localparam logic [15:0] ADDR_WAKE_TIMER_COUNT_LOW = 16'h2f65;
   localparam logic [15:0] ADDR_WAKE_TIMER_CAPTURE_HIGH = 16'h2f66;
   localparam logic [15:0] ADDR_WAKE_TIMER_CAPTURE_LOW = 16'h2f67;
   localparam logic [15:0] ADDR_SIGNAL_STRENGTH_HIGH = 16'h2f71;
   localparam logic [15:0] ADDR_SIGNAL_STRENGTH_LOW = 16'h2f72;
   localparam logic [15:0] ADDR_GAIN_OFFSET = 16'h2f73;
   // -----------------------------------------------------------------
   // Reset values and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_STRENGTH_HIGH = 8'h80;
   localparam logic [11:0] STRENGTH_INVALID = 12'h800;
   localparam logic [3:0] SELF_TEST_FIELD_MASK = 4'hf;
   localparam int STRENGTH_LOW_LSB = 3;
   localparam int STRENGTH_LOW_MSB = 6;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : rsc_pkg

/* File: rtl/rsc_snapshot.sv */
// Snapshot register: loads a value on a strobe, holds it otherwise
`timescale 1ns/1ns
module rsc_snapshot import rsc_pkg::*; #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Load side
   input wire logic load,
   input wire logic [WIDTH-1:0] value_in,
   // Held value
   output logic [WIDTH-1:0] value_reg
);
   // Whole word loads in one edge so its bytes never mix samples
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         value_reg <= RESET_VALUE;
      end else if (load) begin
         value_reg <= value_in;
      end
   end
endmodule : rsc_snapshot

/* File: rtl/rsc_word_reg.sv */
// Software-written 16-bit value held as a high and a low byte
`timescale 1ns/1ns
module rsc_word_reg import rsc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Byte write strobes
   input wire logic wr_high,
   input wire logic wr_low,
   input wire logic [7:0] wr_data,
   // Held value
   output logic [15:0] word_reg
);
   // Each byte updates on its own strobe, both clear at reset
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         word_reg <= {RST_ZERO, RST_ZERO};
      end else begin
         if (wr_high) begin
            word_reg[15:8] <= wr_data;
         end
         if (wr_low) begin
            word_reg[7:0] <= wr_data;
         end
      end
   end
endmodule : rsc_word_reg

/* File: sim/tb_top.sv */
// Self-checking testbench of the radio status and calibration register bank
`timescale 1ns/1ns
module tb_top import rsc_pkg::*;;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic core_clk;
   logic reset_n;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [15:0] wake_timer_value;
   logic sync_detect;
   logic [11:0] strength_raw;
   logic strength_update;
   logic [15:0] dc_real_value;
   logic [15:0] dc_imag_value;
   logic [15:0] imbalance_real_value;
   logic [15:0] imbalance_imag_value;
   logic [3:0] self_test_field;
   int n_mismatch = 0;
   int n_tests = 0;

   rsc_regs u_rsc_regs (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_timer_value(wake_timer_value),
      .sync_detect(sync_detect), .strength_raw(strength_raw), .strength_update(strength_update),
      .dc_real_value(dc_real_value), .dc_imag_value(dc_imag_value),
      .imbalance_real_value(imbalance_real_value), .imbalance_imag_value(imbalance_imag_value),
      .self_test_field(self_test_field)
   );

   // 125 MHz clock
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // Compare, bus and closing tasks
   // ----------------------------------------------------------------
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check8

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check16

   // One-cycle write strobe, launched and released right after rising edges
   task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stands only in the cycle after the strobe edge
   task automatic read_check(input logic [15:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check8(reg_rdata, exp);
   endtask : read_check

   task automatic conclude();
      $display("Comparisons: %0d, mismatches: %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Every mapped byte after reset; only the strength high byte is non-zero
   task automatic test_reset();
      logic [15:0] a;
      for (int i = 0; i < 16; i++) begin
         a = ADDR_WAKE_TIMER_COUNT_HIGH + 16'(i);
         read_check(a, (a == ADDR_SIGNAL_STRENGTH_HIGH) ? RST_STRENGTH_HIGH : RST_ZERO);
      end
   endtask : test_reset

   // Four read/write words, written one after another with boundary patterns
   task automatic test_words();
      logic [15:0] ha [4] = '{ADDR_DC_OFFSET_REAL_HIGH, ADDR_DC_OFFSET_IMAG_HIGH,
                              ADDR_IQ_IMBALANCE_REAL_HIGH, ADDR_IQ_IMBALANCE_IMAG_HIGH};
      logic [15:0] la [4] = '{ADDR_DC_OFFSET_REAL_LOW, ADDR_DC_OFFSET_IMAG_LOW,
                              ADDR_IQ_IMBALANCE_REAL_LOW, ADDR_IQ_IMBALANCE_IMAG_LOW};
      logic [15:0] v [4] = '{16'h8001, 16'h7ffe, 16'hff00, 16'h00ff};
      for (int i = 0; i < 4; i++) begin
         reg_write(ha[i], v[i][15:8]);
         reg_write(la[i], v[i][7:0]);
      end
      for (int i = 0; i < 4; i++) begin
         read_check(ha[i], v[i][15:8]);
         read_check(la[i], v[i][7:0]);
      end
      check16(dc_real_value, v[0]);
      check16(dc_imag_value, v[1]);
      check16(imbalance_real_value, v[2]);
      check16(imbalance_imag_value, v[3]);
      reg_write(ADDR_DC_OFFSET_REAL_LOW, 8'h5a);
      @(posedge core_clk);
      #1;
      check16(dc_real_value, 16'h805a);
   endtask : test_words

   // Upper nibble of the self-test byte ignores writes and reads zero
   task automatic test_self_test();
      reg_write(ADDR_SELF_TEST_CONFIG, 8'hff);
      read_check(ADDR_SELF_TEST_CONFIG, 8'h0f);
      check16({12'h000, self_test_field}, 16'h000f);
      reg_write(ADDR_SELF_TEST_CONFIG, 8'ha5);
      read_check(ADDR_SELF_TEST_CONFIG, 8'h05);
   endtask : test_self_test

   // Writes to read-only and unmapped places change nothing
   task automatic test_refused();
      reg_write(ADDR_WAKE_TIMER_CAPTURE_LOW, 8'hff);
      reg_write(ADDR_WAKE_TIMER_COUNT_LOW, 8'hff);
      reg_write(ADDR_SIGNAL_STRENGTH_HIGH, 8'h00);
      reg_write(16'h2f74, 8'hff);
      read_check(ADDR_WAKE_TIMER_CAPTURE_LOW, RST_ZERO);
      read_check(ADDR_WAKE_TIMER_COUNT_LOW, RST_ZERO);
      read_check(ADDR_SIGNAL_STRENGTH_HIGH, RST_STRENGTH_HIGH);
      read_check(16'h2f74, UNMAPPED_READ);
   endtask : test_refused

   // Sync detect captures the timer; later timer changes leave it alone
   task automatic test_capture();
      @(posedge core_clk);
      wake_timer_value <= 16'h1234;
      sync_detect <= 1'b1;
      @(posedge core_clk);
      sync_detect <= 1'b0;
      wake_timer_value <= 16'h5678;
      repeat (3) @(posedge core_clk);
      read_check(ADDR_WAKE_TIMER_CAPTURE_HIGH, 8'h12);
      read_check(ADDR_WAKE_TIMER_CAPTURE_LOW, 8'h34);
   endtask : test_capture

   // Reading the low count byte freezes the high byte until it is read
   task automatic test_count();
      @(posedge core_clk);
      wake_timer_value <= 16'habcd;
      repeat (3) @(posedge core_clk);
      read_check(ADDR_WAKE_TIMER_COUNT_LOW, 8'hcd);
      @(posedge core_clk);
      wake_timer_value <= 16'h1111;
      repeat (2) @(posedge core_clk);
      read_check(ADDR_WAKE_TIMER_COUNT_HIGH, 8'hab);
      read_check(ADDR_WAKE_TIMER_COUNT_LOW, 8'h11);
      read_check(ADDR_WAKE_TIMER_COUNT_HIGH, 8'h11);
   endtask : test_count

   // Strobes with no gap: write then read, low then high count, read right after a capture
   task automatic test_back_to_back();
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= ADDR_IQ_IMBALANCE_REAL_HIGH;
      reg_wdata <= 8'h3c;
      wake_timer_value <= 16'h2468;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_addr <= ADDR_WAKE_TIMER_COUNT_LOW;
      wake_timer_value <= 16'h9999;
      #1;
      check8(reg_rdata, 8'h3c);
      @(posedge core_clk);
      reg_addr <= ADDR_WAKE_TIMER_COUNT_HIGH;
      #1;
      check8(reg_rdata, 8'h68);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      wake_timer_value <= 16'hbeef;
      sync_detect <= 1'b1;
      #1;
      check8(reg_rdata, 8'h24);
      @(posedge core_clk);
      sync_detect <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= ADDR_WAKE_TIMER_CAPTURE_LOW;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check8(reg_rdata, 8'hef);
      read_check(ADDR_WAKE_TIMER_CAPTURE_HIGH, 8'hbe);
   endtask : test_back_to_back

   // Offset in whole dB is taken off the raw 1/16 dB reading; invalid passes
   task automatic strength_step(input logic [7:0] gain, input logic [11:0] raw);
      logic [11:0] e;
      e = (raw == STRENGTH_INVALID) ? raw : raw - {gain, 4'h0};
      reg_write(ADDR_GAIN_OFFSET, gain);
      @(posedge core_clk);
      strength_raw <= raw;
      strength_update <= 1'b1;
      @(posedge core_clk);
      strength_update <= 1'b0;
      repeat (2) @(posedge core_clk);
      read_check(ADDR_SIGNAL_STRENGTH_HIGH, e[11:4]);
      read_check(ADDR_SIGNAL_STRENGTH_LOW, {1'b0, e[3:0], 3'b000});
   endtask : strength_step

   task automatic test_strength();
      read_check(ADDR_GAIN_OFFSET, RST_ZERO);
      strength_step(8'h00, 12'h7a5);
      strength_step(8'h02, 12'h105);
      strength_step(8'hfe, 12'h0e5);
      strength_step(8'h02, 12'h800);
      read_check(ADDR_GAIN_OFFSET, 8'h02);
   endtask : test_strength

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      wake_timer_value = 16'h0000;
      sync_detect = 1'b0;
      strength_raw = 12'h800;
      strength_update = 1'b0;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      test_reset();
      test_words();
      test_self_test();
      test_refused();
      test_capture();
      test_count();
      test_back_to_back();
      test_strength();
      conclude();
   end

   // Tests need well under a thousand cycles
   initial begin
      #40000;
      n_mismatch++;
      conclude();
   end
endmodule : tb_top
